// ===== core/bz_params.svh
// constants of the buzzer control block: offsets, bits, resets, timing
// assumes a 20 MHz system clock and a 32-bit AHB-Lite register bus
`ifndef BZ_PARAMS_SVH
`define BZ_PARAMS_SVH
// ==========================================
// clock and timing
`define BZ_CLK_HZ         20000000
`define BZ_CYC_PER_MS     (`BZ_CLK_HZ / 1000)
`define BZ_REL_LONG_MS    1000
`define BZ_REL_SHORT_MS   500
`define BZ_SHOT_LONG_MS   250
`define BZ_SHOT_SHORT_MS  125
`define BZ_TONE_HZ        4096
`define BZ_TONE_HALF_CYC  (`BZ_CLK_HZ / (2 * `BZ_TONE_HZ))
`define BZ_ENV_LEVELS     16
`define BZ_ENV_MAX        4'hF
// ==========================================
// register indices (byte address is four times the index)
`define BZ_IDX_ENV        16'hFF6C
`define BZ_IDX_SHOT       16'hFF6D
`define BZ_REG_RESET      4'h0
// ==========================================
// bit positions, envelope and output control
`define BZ_BIT_OUTEN      0
`define BZ_BIT_ENVON      1
`define BZ_BIT_RESTART    2
`define BZ_BIT_RELSEL     3
// bit positions, one-shot control
`define BZ_BIT_WIDTH      0
`define BZ_BIT_TRIG       1
`define BZ_BIT_STOP       2
`endif

// ===== core/bz_pkg.sv
// types shared by the buzzer control block
// assumes nothing beyond a SystemVerilog tool
package bz_pkg;
  // ==========================================
  // counters wide enough for one second at 20 MHz
  typedef logic [24:0] bz_cnt_t;
  // one-shot state, gray order along idle to busy
  typedef enum logic [1:0]
  {
    BZ_SHOT_IDLE = 2'h0,
    BZ_SHOT_BUSY = 2'h1
  } bz_shot_e;
  // register selected in the address phase
  typedef enum logic [1:0]
  {
    BZ_SEL_NONE = 2'h0,
    BZ_SEL_ENV  = 2'h1,
    BZ_SEL_SHOT = 2'h3
  } bz_sel_e;
  // ==========================================
  // state of the envelope generator
  typedef struct packed
  {
    logic [3:0] level;    // present envelope level
    logic [3:0] pwm;      // duty ramp
    bz_cnt_t    stepCnt;  // cycles to next level step
    logic       gate;     // tone gate out
  } bz_env_s;
  // state of the control top
  typedef struct packed
  {
    logic        dpValid;    // data phase pending
    logic        dpWrite;    // pending is a write
    bz_sel_e     dpSel;      // pending register
    logic        outEnable;  // buzzer output enable
    logic        envOn;      // envelope on
    logic        relSel;     // long release
    logic        widthSel;   // long one-shot
    logic        restart;    // envelope restart pulse
    bz_shot_e    shot;       // one-shot state
    bz_cnt_t     shotCnt;    // one-shot cycles left
    bz_cnt_t     toneCnt;    // tone half period count
    logic        toneBit;    // raw square tone
    logic [31:0] hrdata;     // read data
    logic        buzzerOut;  // pin level
    logic        buzzerEn;   // pin drive enable
  } bz_ctrl_s;
endpackage : bz_pkg

// ===== core/bz_env_if.sv
// link between the control top and the envelope generator
// assumes both ends on the same clock
`timescale 1ns/10ps
interface bz_env_if;
  logic envOn;        // envelope applied
  logic releaseLong;  // long release time
  logic restart;      // one-cycle restart pulse
  logic gate;         // tone gate from generator
  modport ctrl
  (
    output envOn,
    output releaseLong,
    output restart,
    input  gate
  );
  modport gen
  (
    input  envOn,
    input  releaseLong,
    input  restart,
    output gate
  );
endinterface : bz_env_if

// ===== core/bz_envelope_gen.sv
// decaying envelope: level falls step by step over the release time
// assumes the restart pulse and selects come from the same clock
`timescale 1ns/10ps
`include "bz_params.svh"
module bz_envelope_gen #(
  parameter int unsigned STEP_LONG  = 1250000,
  parameter int unsigned STEP_SHORT = 625000
)(
  input  wire logic clk,
  input  wire logic rst,
  bz_env_if.gen     env
);
  bz_pkg::bz_env_s s;       // registered state
  bz_pkg::bz_env_s next_s;  // next state
  bz_pkg::bz_cnt_t stepLen; // selected step length minus one

  // ==========================================
  // elaboration check
  if (STEP_LONG < 1 || STEP_SHORT < 1 || STEP_LONG > 33554432 || STEP_SHORT > 33554432)
  begin : g_chk
    $error("envelope step length out of range");
  end

  assign env.gate = s.gate;

  // ==========================================
  // next state
  always_comb
  begin
    next_s = s;
    stepLen = env.releaseLong ? bz_pkg::bz_cnt_t'(STEP_LONG - 1)
                              : bz_pkg::bz_cnt_t'(STEP_SHORT - 1);
    next_s.pwm = s.pwm + 4'h1;
    if (env.restart)
    begin
      next_s.level   = `BZ_ENV_MAX;
      next_s.stepCnt = stepLen;
    end
    else if (!env.envOn)
    begin
      // hold at top while off
      next_s.level   = `BZ_ENV_MAX;
      next_s.stepCnt = stepLen;
    end
    else if (s.stepCnt == '0)
    begin
      // one level down per step
      next_s.stepCnt = stepLen;
      if (s.level != 4'h0)
      begin
        next_s.level = s.level - 4'h1;
      end
    end
    else
    begin
      next_s.stepCnt = s.stepCnt - 25'h0000001;
    end
    next_s.gate = !env.envOn || (s.pwm < s.level);
  end

  // ==========================================
  // state register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '{level: `BZ_ENV_MAX, pwm: 4'h0, stepCnt: 25'h0000000, gate: 1'b1};
    end
    else
    begin
      s <= next_s;
    end
  end
endmodule : bz_envelope_gen

// ===== core/bz_ctrl.sv
// buzzer control top: AHB-Lite registers, tone, one-shot, envelope
// assumes one 20 MHz clock and a single AHB-Lite master
// assumes word transfers only: hsize is not decoded
// assumes an external pin stage that drives only while buzzerOutEn is high
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`include "bz_params.svh"
module bz_ctrl #(
  parameter int unsigned REL_LONG_CYC   = `BZ_CYC_PER_MS * `BZ_REL_LONG_MS,
  parameter int unsigned REL_SHORT_CYC  = `BZ_CYC_PER_MS * `BZ_REL_SHORT_MS,
  parameter int unsigned SHOT_LONG_CYC  = `BZ_CYC_PER_MS * `BZ_SHOT_LONG_MS,
  parameter int unsigned SHOT_SHORT_CYC = `BZ_CYC_PER_MS * `BZ_SHOT_SHORT_MS,
  parameter int unsigned TONE_HALF_CYC  = `BZ_TONE_HALF_CYC
)(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             buzzerOut,
  output logic             buzzerOutEn,
  output logic             oneshotBusy
);
  // ==========================================
  // derived constants
  localparam int unsigned STEP_LONG  = REL_LONG_CYC / `BZ_ENV_LEVELS;
  localparam int unsigned STEP_SHORT = REL_SHORT_CYC / `BZ_ENV_LEVELS;
  localparam logic [31:0] ENV_ADDR   = {14'h0000, `BZ_IDX_ENV, 2'h0};
  localparam logic [31:0] SHOT_ADDR  = {14'h0000, `BZ_IDX_SHOT, 2'h0};

  // ==========================================
  // register map, data in bits 3:0, bits 31:4 read zero
  // envelope and output control, byte address four times its index
  //   bit 0 output enable, read and write
  //   bit 1 envelope on, read and write
  //   bit 2 envelope restart, write only, reads zero
  //   bit 3 release select, 1 long, 0 short
  // one-shot control
  //   bit 0 width select, read and write
  //   bit 1 trigger on write, busy on read
  //   bit 2 stop, write only, reads zero
  //   bit 3 unused, reads zero

  // ==========================================
  // timing seen from the bus
  //   a write lands at the edge that ends its data phase
  //   read data is captured at the end of the address phase and stands
  //   for the data phase only, so a read straight after a write sees it
  //   the pin follows the enable bit one cycle after the register
  //   the one-shot stays busy for its width in cycles after the write
  // hazards
  //   trigger and stop in one write: trigger wins, the count restarts
  //   trigger on the expiry cycle also wins, so no pulse is lost
  //   byte or halfword writes act as word writes

  // ==========================================
  // elaboration check: counters hold 25 bits
  if (STEP_LONG < 1 || STEP_SHORT < 1 || SHOT_LONG_CYC < 1 ||
      SHOT_SHORT_CYC < 1 || TONE_HALF_CYC < 1 ||
      SHOT_LONG_CYC > 33554432 || SHOT_SHORT_CYC > 33554432 ||
      TONE_HALF_CYC > 33554432)
  begin : g_chk
    $error("buzzer timing parameter out of range");
  end

  // ==========================================
  // state and wiring
  bz_pkg::bz_ctrl_s s;        // registered state
  bz_pkg::bz_ctrl_s next_s;   // next state
  logic             addrTake; // address phase accepted
  logic             wrEnv;    // write to envelope register
  logic             wrShot;   // write to one-shot register
  bz_pkg::bz_sel_e  sel;      // decoded register
  bz_env_if         envLink (); // link to envelope generator

  // hsize is not checked: only word transfers are used
  assign addrTake = hsel && htrans[1] && hready;
  assign wrEnv    = s.dpValid && s.dpWrite && (s.dpSel == bz_pkg::BZ_SEL_ENV);
  assign wrShot   = s.dpValid && s.dpWrite && (s.dpSel == bz_pkg::BZ_SEL_SHOT);

  // address decode, unmapped goes to none
  always_comb
  begin
    if (haddr == ENV_ADDR)
    begin
      // envelope and output control
      sel = bz_pkg::BZ_SEL_ENV;
    end
    else if (haddr == SHOT_ADDR)
    begin
      // one-shot control
      sel = bz_pkg::BZ_SEL_SHOT;
    end
    else
    begin
      // unmapped: reads zero, writes dropped
      sel = bz_pkg::BZ_SEL_NONE;
    end
  end

  // ==========================================
  // envelope generator
  // the restart pulse lasts one cycle; the generator reloads its
  // step counter with it, so the first step after a restart is whole
  assign envLink.envOn       = s.envOn;
  assign envLink.releaseLong = s.relSel;
  assign envLink.restart     = s.restart;

  bz_envelope_gen #(
    .STEP_LONG  (STEP_LONG),
    .STEP_SHORT (STEP_SHORT)
  ) u_env (
    .clk (clk),
    .rst (rst),
    .env (envLink)
  );

  // ==========================================
  // next state
  always_comb
  begin
    next_s         = s;
    next_s.restart = 1'b0;

    // address phase capture
    next_s.dpValid = addrTake;
    next_s.dpWrite = hwrite;
    next_s.dpSel   = addrTake ? sel : bz_pkg::BZ_SEL_NONE;

    // envelope and output register write
    if (wrEnv)
    begin
      next_s.outEnable = hwdata[`BZ_BIT_OUTEN];
      next_s.envOn     = hwdata[`BZ_BIT_ENVON];
      next_s.relSel    = hwdata[`BZ_BIT_RELSEL];
      next_s.restart   = hwdata[`BZ_BIT_RESTART];
    end

    case (s.shot)
      bz_pkg::BZ_SHOT_IDLE:
      begin
        // ready, counter parked at zero
        next_s.shotCnt = '0;
      end
      bz_pkg::BZ_SHOT_BUSY:
      begin
        if (s.shotCnt == '0)
        begin
          // width elapsed, back to ready
          next_s.shot = bz_pkg::BZ_SHOT_IDLE;
        end
        else
        begin
          // still busy, one cycle less to go
          next_s.shotCnt = s.shotCnt - 25'h0000001;
        end
      end
      default:
      begin
        // unused code falls back to ready
        next_s.shot    = bz_pkg::BZ_SHOT_IDLE;
        next_s.shotCnt = '0;
      end
    endcase

    // one-shot register write
    if (wrShot)
    begin
      next_s.widthSel = hwdata[`BZ_BIT_WIDTH];
      if (hwdata[`BZ_BIT_STOP])
      begin
        next_s.shot    = bz_pkg::BZ_SHOT_IDLE;
        next_s.shotCnt = '0;
      end
      // trigger starts, wins over expiry and stop
      if (hwdata[`BZ_BIT_TRIG])
      begin
        next_s.shot    = bz_pkg::BZ_SHOT_BUSY;
        next_s.shotCnt = hwdata[`BZ_BIT_WIDTH] ? bz_pkg::bz_cnt_t'(SHOT_LONG_CYC - 1)
                                               : bz_pkg::bz_cnt_t'(SHOT_SHORT_CYC - 1);
        next_s.restart = 1'b1;
      end
    end

    // read data from next state so a write just before is seen
    next_s.hrdata = 32'h00000000;
    if (addrTake && !hwrite)
    begin
      case (sel)
        // restart bit and D2 read zero
        bz_pkg::BZ_SEL_ENV:
        begin
          next_s.hrdata[`BZ_BIT_OUTEN]  = next_s.outEnable;
          next_s.hrdata[`BZ_BIT_ENVON]  = next_s.envOn;
          next_s.hrdata[`BZ_BIT_RELSEL] = next_s.relSel;
        end
        // stop and unused bits read zero
        bz_pkg::BZ_SEL_SHOT:
        begin
          next_s.hrdata[`BZ_BIT_WIDTH] = next_s.widthSel;
          next_s.hrdata[`BZ_BIT_TRIG]  = (next_s.shot == bz_pkg::BZ_SHOT_BUSY);
        end
        default:
        begin
          // unmapped register reads zero
          next_s.hrdata = 32'h00000000;
        end
      endcase
    end

    // tone divider, square wave
    if (s.toneCnt == '0)
    begin
      // half period over: reload and flip the tone
      next_s.toneCnt = bz_pkg::bz_cnt_t'(TONE_HALF_CYC - 1);
      next_s.toneBit = !s.toneBit;
    end
    else
    begin
      // count down the half period
      next_s.toneCnt = s.toneCnt - 25'h0000001;
    end

    next_s.buzzerEn  = s.outEnable;
    next_s.buzzerOut = s.outEnable && s.toneBit && envLink.gate;
  end

  // ==========================================
  // state register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      // all register bits clear, pin undriven, one-shot ready
      s <= '{dpValid:   1'b0,
             dpWrite:   1'b0,
             dpSel:     bz_pkg::BZ_SEL_NONE,
             outEnable: 1'b0,
             envOn:     1'b0,
             relSel:    1'b0,
             widthSel:  1'b0,
             restart:   1'b0,
             shot:      bz_pkg::BZ_SHOT_IDLE,
             shotCnt:   25'h0000000,
             toneCnt:   25'h0000000,
             toneBit:   1'b0,
             hrdata:    32'h00000000,
             buzzerOut: 1'b0,
             buzzerEn:  1'b0};
    end
    else
    begin
      s <= next_s;
    end
  end

  // ==========================================
  // outputs straight from the state register
  // handshake outputs are flops as well, so they never glitch
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end
    else
    begin
      // zero wait state, always OKAY
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end
  end

  assign hrdata      = s.hrdata;
  assign buzzerOut   = s.buzzerOut;
  assign buzzerOutEn = s.buzzerEn;
  // busy is the only state with bit 0 set, so the status is a flop bit
  assign oneshotBusy = s.shot[0];
endmodule : bz_ctrl

// ===== dv/bz_ctrl_assertions.sv
// checker for the buzzer control top, sees its ports only
// assumes the AHB-Lite master holds each address phase one cycle
`timescale 1ns/10ps
`include "bz_params.svh"
module bz_ctrl_assertions #(
  parameter int unsigned SHOT_LONG_CYC  = 200,
  parameter int unsigned SHOT_SHORT_CYC = 100
)(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        buzzerOut,
  input wire logic        buzzerOutEn,
  input wire logic        oneshotBusy
);
  // ==========================================
  // data phase tracking
  logic       dpV, dpW;
  logic [1:0] dpR;  // 1 envelope, 2 one-shot, 0 unmapped
  logic       wLong, stopped;
  int         busyLen;
  wire wrEnv  = dpV && dpW && dpR == 2'h1;
  wire wrShot = dpV && dpW && dpR == 2'h2;
  wire rdAny  = dpV && !dpW;
  // decode address phase, track one-shot length
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dpV <= 1'b0;
      dpW <= 1'b0;
      dpR <= 2'h0;
      wLong <= 1'b0;
      stopped <= 1'b0;
      busyLen <= 0;
    end
    else
    begin
      dpV <= hsel && htrans[1] && hready;
      dpW <= hwrite;
      dpR <= (haddr == {14'h0, `BZ_IDX_ENV, 2'h0}) ? 2'h1 :
             (haddr == {14'h0, `BZ_IDX_SHOT, 2'h0}) ? 2'h2 : 2'h0;
      if (wrShot && hwdata[1])
      begin
        wLong <= hwdata[0];
        stopped <= 1'b0;
      end
      else if (wrShot && hwdata[2])
        stopped <= 1'b1;
      busyLen <= oneshotBusy ? busyLen + 1 : 0;
    end
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  a_pin_needs_en: assert property (!buzzerOutEn && !$past(buzzerOutEn) |-> !buzzerOut)
    else $error("pin active while disabled");
  a_en_follows: assert property (wrEnv |-> ##3 buzzerOutEn == $past(hwdata[0], 3))
    else $error("enable not following write");
  a_trig_busy: assert property (wrShot && hwdata[1] |=> oneshotBusy)
    else $error("trigger did not set busy");
  a_stop_ready: assert property (wrShot && hwdata[2] && !hwdata[1] |=> !oneshotBusy)
    else $error("stop did not end one-shot");
  a_busy_cause: assert property ($rose(oneshotBusy) |-> $past(wrShot && hwdata[1]))
    else $error("busy without trigger");
  a_busy_length: assert property ($fell(oneshotBusy) && !stopped
    && !$past(rst) |->
    busyLen >= (wLong ? SHOT_LONG_CYC : SHOT_SHORT_CYC) &&
    busyLen <= (wLong ? SHOT_LONG_CYC : SHOT_SHORT_CYC) + 2)
    else $error("one-shot length wrong");
  a_read_zeros: assert property (rdAny && dpR != 2'h0 |->
    hrdata[31:4] == 28'h0 && !hrdata[2] && (dpR == 2'h1 || !hrdata[3]))
    else $error("unused or write-only bit read one");
  a_unmapped_zero: assert property (rdAny && dpR == 2'h0 |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule : bz_ctrl_assertions
bind bz_ctrl bz_ctrl_assertions #(.SHOT_LONG_CYC(SHOT_LONG_CYC),
  .SHOT_SHORT_CYC(SHOT_SHORT_CYC)) chk (.clk(clk), .rst(rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .buzzerOut(buzzerOut), .buzzerOutEn(buzzerOutEn),
  .oneshotBusy(oneshotBusy));

// ===== dv/bz_piezo_model.sv
// piezo buzzer on the output pin: counts tone edges
// assumes the pin is sampled on the system clock
`timescale 1ns/10ps
module bz_piezo_model (
  input wire logic clk,
  input wire logic buzzerOut,
  input wire logic buzzerOutEn
);
  // ==========================================
  int   edges  = 0;  // rising edges heard
  int   faults = 0;  // pin high while undriven
  logic last   = 1'b0;
  // the piezo hears only a driven pin
  always @(posedge clk)
  begin
    if (buzzerOutEn === 1'b1 && buzzerOut === 1'b1 && last === 1'b0)
      edges++;
    if (buzzerOutEn !== 1'b1 && buzzerOut === 1'b1)
      faults++;
    last <= buzzerOut;
  end
endmodule : bz_piezo_model

// ===== dv/tb_bz_ctrl.sv
// self-checking bench of the buzzer control top over AHB-Lite
// assumes the short counts set below on the design parameters
`timescale 1ns/10ps
`include "bz_params.svh"
module tb_bz_ctrl;
  // ==========================================
  localparam logic [31:0] A_ENV  = {14'h0, `BZ_IDX_ENV, 2'h0};
  localparam logic [31:0] A_SHOT = {14'h0, `BZ_IDX_SHOT, 2'h0};
  localparam int SHORT = 100;  // one-shot short width
  localparam int LONG  = 200;  // one-shot long width
  logic clk = 0, rst = 1, hwrite = 0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, buzzerOut, buzzerOutEn, oneshotBusy, resp;
  int failures = 0, tests_run = 0, cycles = 0, n;
  always #25 clk = ~clk;
  bz_ctrl #(.REL_LONG_CYC(320), .REL_SHORT_CYC(160), .SHOT_LONG_CYC(LONG),
    .SHOT_SHORT_CYC(SHORT), .TONE_HALF_CYC(4)) DUT (.clk(clk), .rst(rst), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .buzzerOut(buzzerOut), .buzzerOutEn(buzzerOutEn), .oneshotBusy(oneshotBusy));
  bz_piezo_model buzzer (.clk(clk), .buzzerOut(buzzerOut), .buzzerOutEn(buzzerOutEn));
  // ==========================================
  // one bus transfer, write or read
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    haddr <= a; hwrite <= w; htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    resp = hresp;
  endtask : xfer
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // tone edges heard after a settle time
  task automatic tone(input int settle, input int len);
    repeat (settle) @(posedge clk);
    n = buzzer.edges;
    repeat (len) @(posedge clk);
    n = buzzer.edges - n;
  endtask : tone
  // length of one-shot busy in cycles
  task automatic busy_len();
    #1 n = 0;
    while (oneshotBusy === 1'b1 && n < 1000)
    begin
      @(posedge clk);
      #1 n++;
    end
  endtask : busy_len
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // cut a hang short
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      print_verdict();
    end
  end
  // ==========================================
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    xfer(0, A_ENV, 0);
    check("env reset", 32'h0, rd);
    xfer(0, A_SHOT, 0);
    check("shot reset", 32'h0, rd);
    xfer(1, A_ENV, 32'hF);
    xfer(0, A_ENV, 0);
    check("env rw", 32'hB, rd);
    xfer(1, 32'h10, 32'hF);
    xfer(0, 32'h10, 0);
    check("unmapped", 32'h0, rd);
    check("bus response", 32'h0, resp);
    // short release from the top level is silent well before 180 cycles
    xfer(1, A_ENV, 32'h7);
    tone(180, 100);
    check("short release", 32'h0, n);
    // restart lifts the level again, a long release still sounds then
    xfer(1, A_ENV, 32'hF);
    tone(180, 100);
    check("long release", 32'h1, n > 0);
    xfer(1, A_ENV, 32'h1);
    tone(10, 100);
    check("no envelope", 32'h1, n >= 12);
    check("pin enable on", 32'h1, buzzerOutEn);
    xfer(1, A_ENV, 32'h0);
    tone(10, 100);
    check("disabled", 32'h0, n);
    check("pin enable off", 32'h0, buzzerOutEn);
    check("pin faults", 32'h0, buzzer.faults);
    xfer(1, A_SHOT, 32'h1);
    xfer(0, A_SHOT, 0);
    check("width rw", 32'h1, rd);
    xfer(1, A_SHOT, 32'h2);
    busy_len();
    check("short shot", 32'(SHORT), n);
    xfer(1, A_SHOT, 32'h3);
    xfer(0, A_SHOT, 0);
    check("busy read", 32'h3, rd);
    // the read back has used three cycles of the long width
    busy_len();
    check("long shot", 32'(LONG - 3), n);
    xfer(1, A_SHOT, 32'h3);
    xfer(1, A_SHOT, 32'h1);
    xfer(0, A_SHOT, 0);
    check("no stop", 32'h3, rd);
    xfer(1, A_SHOT, 32'h5);
    xfer(0, A_SHOT, 0);
    check("stopped", 32'h1, rd);
    print_verdict();
  end
endmodule : tb_bz_ctrl
